// File: core/rsjx_alu.sv
`timescale 1ns/100ps
module rsjx_alu
  import rsjx_pkg::*;
(
  rsjx_alu_if.alu_mp alu
);

  logic [8:0] diff9;
  logic [7:0] diff7;
  logic [4:0] diff4;

  ////////////////////////////////////////////////////////////////////////
  // borrow chains
  always_comb begin
    diff9 = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cin};                  // [RULE_10]
    diff7 = {1'b0, alu.a[6:0]} - {1'b0, alu.b[6:0]} - {7'h00, alu.cin};
    diff4 = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.cin};
  end

  ////////////////////////////////////////////////////////////////////////
  // result select
  always_comb begin
    alu.res  = alu.a;
    alu.cout = alu.cin;
    alu.aout = 1'b0;
    alu.vout = 1'b0;
    unique case (alu.op)
      ALU_ROT: begin
        alu.res = {alu.a[0], alu.a[7:1]};                                      // [RULE_01]
      end
      ALU_ROT_CY: begin
        alu.res  = {alu.cin, alu.a[7:1]};                                      // [RULE_04]
        alu.cout = alu.a[0];                                                   // [RULE_03]
      end
      ALU_SUB: begin
        alu.res  = diff9[7:0];                                                 // [RULE_10]
        alu.cout = diff9[8];                                                   // [RULE_11]
        alu.aout = diff4[4];                                                   // [RULE_12]
        alu.vout = diff9[8] ^ diff7[7];                                        // [RULE_13]
      end
      ALU_PASS: begin
        alu.res = alu.a;
      end
    endcase
  end

endmodule : rsjx_alu

// File: core/rsjx_alu_if.sv
`timescale 1ns/100ps
interface rsjx_alu_if;
  import rsjx_pkg::*;
  rsjx_alu_op_t op;
  logic [7:0]   a;
  logic [7:0]   b;
  logic         cin;
  logic [7:0]   res;
  logic         cout;
  logic         aout;
  logic         vout;

  modport exec_mp (output op, a, b, cin, input res, cout, aout, vout);
  modport alu_mp  (input op, a, b, cin, output res, cout, aout, vout);
endinterface : rsjx_alu_if

// File: core/rsjx_exec.sv
`timescale 1ns/100ps
module rsjx_exec
  import rsjx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_opcode,
  input  wire logic [7:0]  instr_byte2,
  input  wire logic [15:0] instr_pc,
  output logic             instr_ready,
  output logic             src_rd_en,
  output rsjx_src_t        src_mode,
  output logic [7:0]       src_addr,
  input  wire logic [7:0]  src_data,
  input  wire logic        acc_load,
  input  wire logic [7:0]  acc_load_data,
  input  wire logic        flag_load,
  input  wire logic [2:0]  flag_load_data,
  output logic [7:0]       acc,
  output logic             carry_flag,
  output logic             aux_carry_flag,
  output logic             overflow_flag,
  output logic             bit_wr_en,
  output logic [7:0]       bit_wr_addr,
  output logic             pc_load,
  output logic [15:0]      pc_target,
  output logic             exec_done,
  output logic             illegal_op
);

  rsjx_alu_if alu_bus ();

  rsjx_alu u_alu (
    .alu (alu_bus.alu_mp)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  rsjx_state_t state;
  rsjx_state_t next_state;
  logic [15:0] jump_base;
  logic [15:0] next_jump_base;
  logic [7:0]  jump_rel;
  logic [7:0]  next_jump_rel;
  logic [7:0]  next_acc;
  logic        next_carry_flag;
  logic        next_aux_carry_flag;
  logic        next_overflow_flag;
  logic        next_bit_wr_en;
  logic [7:0]  next_bit_wr_addr;
  logic        next_pc_load;
  logic [15:0] next_pc_target;
  logic        next_exec_done;
  logic        next_illegal_op;

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic accept;
  logic dec_rot;
  logic dec_rot_cy;
  logic dec_set_carry;
  logic dec_set_bit;
  logic dec_jump;
  logic dec_sub_reg;
  logic dec_sub_dir;
  logic dec_sub_ind;
  logic dec_sub_imm;
  logic dec_sub;

  assign instr_ready   = (state == ST_IDLE);                                   // [RULE_08]
  assign accept        = instr_valid && instr_ready;
  assign dec_rot       = (instr_opcode == OP_ROT_RIGHT);                       // [RULE_15]
  assign dec_rot_cy    = (instr_opcode == OP_ROT_RIGHT_CY);                    // [RULE_03]
  assign dec_set_carry = (instr_opcode == OP_SET_CARRY);                       // [RULE_16]
  assign dec_set_bit   = (instr_opcode == OP_SET_BIT);                         // [RULE_06]
  assign dec_jump      = (instr_opcode == OP_SHORT_JUMP);                      // [RULE_07]
  assign dec_sub_reg   = ((instr_opcode & OP_SUB_REG_MASK) == OP_SUB_REG);     // [RULE_14]
  assign dec_sub_dir   = (instr_opcode == OP_SUB_DIR);                         // [RULE_14]
  assign dec_sub_ind   = ((instr_opcode & OP_SUB_IND_MASK) == OP_SUB_IND);     // [RULE_14]
  assign dec_sub_imm   = (instr_opcode == OP_SUB_IMM);                         // [RULE_14]
  assign dec_sub       = dec_sub_reg || dec_sub_dir || dec_sub_ind || dec_sub_imm;

  ////////////////////////////////////////////////////////////////////////
  // operand fetch request
  always_comb begin
    src_rd_en = instr_valid && instr_ready && dec_sub && !dec_sub_imm;
    src_mode  = SRC_IMM;
    src_addr  = instr_byte2;
    if (dec_sub_reg) begin
      src_mode = SRC_REG;                                                      // [RULE_14]
      src_addr = {5'h00, instr_opcode[2:0]};
    end else if (dec_sub_ind) begin
      src_mode = SRC_IND;                                                      // [RULE_14]
      src_addr = {7'h00, instr_opcode[0]};
    end else if (dec_sub_dir) begin
      src_mode = SRC_DIR;                                                      // [RULE_14]
      src_addr = instr_byte2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alu operands
  always_comb begin
    alu_bus.a   = acc;
    alu_bus.cin = carry_flag;
    alu_bus.b   = dec_sub_imm ? instr_byte2 : src_data;                        // [RULE_14]
    if (dec_rot) begin
      alu_bus.op = ALU_ROT;
    end else if (dec_rot_cy) begin
      alu_bus.op = ALU_ROT_CY;
    end else if (dec_sub) begin
      alu_bus.op = ALU_SUB;
    end else begin
      alu_bus.op = ALU_PASS;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    next_state          = state;
    next_jump_base      = jump_base;
    next_jump_rel       = jump_rel;
    next_acc            = acc;
    next_carry_flag     = carry_flag;
    next_aux_carry_flag = aux_carry_flag;
    next_overflow_flag  = overflow_flag;
    next_bit_wr_en      = 1'b0;
    next_bit_wr_addr    = bit_wr_addr;
    next_pc_load        = 1'b0;
    next_pc_target      = pc_target;
    next_exec_done      = 1'b0;
    next_illegal_op     = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (acc_load) begin
          next_acc = acc_load_data;
        end
        if (flag_load) begin
          next_carry_flag     = flag_load_data[2];
          next_aux_carry_flag = flag_load_data[1];
          next_overflow_flag  = flag_load_data[0];
        end
        if (accept) begin
          next_exec_done = 1'b1;
          if (dec_rot) begin
            next_acc            = alu_bus.res;                                 // [RULE_01]
            next_carry_flag     = carry_flag;                                  // [RULE_02]
            next_aux_carry_flag = aux_carry_flag;                              // [RULE_02]
            next_overflow_flag  = overflow_flag;                               // [RULE_02]
          end else if (dec_rot_cy) begin
            next_acc            = alu_bus.res;                                 // [RULE_04]
            next_carry_flag     = alu_bus.cout;                                // [RULE_03]
            next_aux_carry_flag = aux_carry_flag;                              // [RULE_04]
            next_overflow_flag  = overflow_flag;                               // [RULE_04]
          end else if (dec_set_carry) begin
            next_carry_flag     = 1'b1;                                        // [RULE_05]
            next_aux_carry_flag = aux_carry_flag;                              // [RULE_05]
            next_overflow_flag  = overflow_flag;                               // [RULE_05]
          end else if (dec_set_bit) begin
            next_bit_wr_en   = 1'b1;                                           // [RULE_05]
            next_bit_wr_addr = instr_byte2;                                    // [RULE_06]
          end else if (dec_jump) begin
            next_exec_done = 1'b0;
            next_state     = ST_JUMP;                                          // [RULE_08]
            next_jump_base = instr_pc + PC_STEP_JUMP;                          // [RULE_08]
            next_jump_rel  = instr_byte2;                                      // [RULE_07]
          end else if (dec_sub) begin
            next_acc            = alu_bus.res;                                 // [RULE_10]
            next_carry_flag     = alu_bus.cout;                                // [RULE_11]
            next_aux_carry_flag = alu_bus.aout;                                // [RULE_12]
            next_overflow_flag  = alu_bus.vout;                                // [RULE_13]
          end else begin
            next_exec_done  = 1'b0;
            next_illegal_op = 1'b1;
          end
        end
      end
      ST_JUMP: begin
        if (acc_load) begin
          next_acc = acc_load_data;
        end
        if (flag_load) begin
          next_carry_flag     = flag_load_data[2];
          next_aux_carry_flag = flag_load_data[1];
          next_overflow_flag  = flag_load_data[0];
        end
        next_pc_target = jump_base + rsjx_sext8(jump_rel);                     // [RULE_07] [RULE_09]
        next_pc_load   = 1'b1;                                                 // [RULE_08]
        next_exec_done = 1'b1;
        next_state     = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state          <= ST_IDLE;
      jump_base      <= PC_RESET;
      jump_rel       <= ACC_RESET;
      acc            <= ACC_RESET;
      carry_flag     <= 1'b0;
      aux_carry_flag <= 1'b0;
      overflow_flag  <= 1'b0;
      bit_wr_en      <= 1'b0;
      bit_wr_addr    <= ACC_RESET;
      pc_load        <= 1'b0;
      pc_target      <= PC_RESET;
      exec_done      <= 1'b0;
      illegal_op     <= 1'b0;
    end else begin
      state          <= next_state;
      jump_base      <= next_jump_base;
      jump_rel       <= next_jump_rel;
      acc            <= next_acc;
      carry_flag     <= next_carry_flag;
      aux_carry_flag <= next_aux_carry_flag;
      overflow_flag  <= next_overflow_flag;
      bit_wr_en      <= next_bit_wr_en;
      bit_wr_addr    <= next_bit_wr_addr;
      pc_load        <= next_pc_load;
      pc_target      <= next_pc_target;
      exec_done      <= next_exec_done;
      illegal_op     <= next_illegal_op;
    end
  end

endmodule : rsjx_exec

// File: core/rsjx_pkg.sv
// Behaviour
// (RULE_01) rotate right moves every accumulator bit down one, bit 0 re-enters at bit 7
// (RULE_02) plain rotate right leaves all status flags, carry included, unchanged
// (RULE_03) rotate through carry is opcode 13h, one byte, old bit 0 goes to carry
// (RULE_04) rotate through carry puts old carry into bit 7, other flags unchanged
// (RULE_05) set bit forces carry or an addressed bit to one, other flags untouched
// (RULE_06) set addressed bit is opcode D2h plus bit address byte, one cycle
// (RULE_07) short jump is opcode 80h plus signed displacement added to program counter
// (RULE_08) short jump adds two to program counter before displacement, takes two cycles
// (RULE_09) short jump reaches 128 bytes before to 127 bytes after the instruction that follows it
// (RULE_10) subtract with borrow stores accumulator minus operand minus carry
// (RULE_11) subtract with borrow sets carry on borrow out of bit 7, else clears
// (RULE_12) subtract with borrow sets aux carry on borrow for bit 3, else clears
// (RULE_13) overflow set when exactly one of bit 6 and bit 7 borrows, else cleared
// (RULE_14) subtract operand from register, direct, register indirect or immediate
// (RULE_15) plain rotate right is opcode 03h, one byte, one cycle
// (RULE_16) set carry is opcode D3h, one byte, one cycle
package rsjx_pkg;

  localparam logic [7:0]  OP_ROT_RIGHT      = 8'h03;
  localparam logic [7:0]  OP_ROT_RIGHT_CY   = 8'h13;
  localparam logic [7:0]  OP_SET_CARRY      = 8'hD3;
  localparam logic [7:0]  OP_SET_BIT        = 8'hD2;
  localparam logic [7:0]  OP_SHORT_JUMP     = 8'h80;
  localparam logic [7:0]  OP_SUB_IMM        = 8'h94;
  localparam logic [7:0]  OP_SUB_DIR        = 8'h95;
  localparam logic [7:0]  OP_SUB_IND        = 8'h96;
  localparam logic [7:0]  OP_SUB_IND_MASK   = 8'hFE;
  localparam logic [7:0]  OP_SUB_REG        = 8'h98;
  localparam logic [7:0]  OP_SUB_REG_MASK   = 8'hF8;
  localparam logic [15:0] PC_STEP_JUMP      = 16'h0002;
  localparam logic [7:0]  ACC_RESET         = 8'h00;
  localparam logic [15:0] PC_RESET          = 16'h0000;

  typedef enum logic [1:0] {
    SRC_REG = 2'b00,
    SRC_DIR = 2'b01,
    SRC_IND = 2'b10,
    SRC_IMM = 2'b11
  } rsjx_src_t;

  typedef enum logic [1:0] {
    ALU_ROT     = 2'b00,
    ALU_ROT_CY  = 2'b01,
    ALU_SUB     = 2'b10,
    ALU_PASS    = 2'b11
  } rsjx_alu_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_JUMP = 1'b1
  } rsjx_state_t;

  function automatic logic [15:0] rsjx_sext8(input logic [7:0] v);
    rsjx_sext8 = {{8{v[7]}}, v};
  endfunction : rsjx_sext8

endpackage : rsjx_pkg

// File: tb/rsjx_exec_assertions.sv
`timescale 1ns/100ps
module rsjx_exec_assertions
  import rsjx_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        instr_valid,
  input wire logic [7:0]  instr_opcode,
  input wire logic [7:0]  instr_byte2,
  input wire logic [15:0] instr_pc,
  input wire logic        instr_ready,
  input wire logic        src_rd_en,
  input wire rsjx_src_t   src_mode,
  input wire logic [7:0]  src_addr,
  input wire logic [7:0]  src_data,
  input wire logic        flag_load,
  input wire logic [7:0]  acc,
  input wire logic        carry_flag,
  input wire logic        aux_carry_flag,
  input wire logic        overflow_flag,
  input wire logic        bit_wr_en,
  input wire logic [7:0]  bit_wr_addr,
  input wire logic        pc_load,
  input wire logic [15:0] pc_target,
  input wire logic        exec_done
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       take;
  logic       is_sub;
  logic [7:0] opnd;
  logic [8:0] d8;
  logic [4:0] d3;
  logic [7:0] d6;
  logic [7:0] op;
  ////////////////////////////////////////////////////////////
  // reference difference and borrows
  always_comb begin
    op     = instr_opcode;
    take   = instr_valid && instr_ready;
    is_sub = op == OP_SUB_IMM || op == OP_SUB_DIR || (op & OP_SUB_IND_MASK) == OP_SUB_IND
             || (op & OP_SUB_REG_MASK) == OP_SUB_REG;
    opnd   = (op == OP_SUB_IMM) ? instr_byte2 : src_data;
    d8     = {1'h0, acc} - {1'h0, opnd} - 9'(carry_flag);
    d3     = {1'h0, acc[3:0]} - {1'h0, opnd[3:0]} - 5'(carry_flag);
    d6     = {1'h0, acc[6:0]} - {1'h0, opnd[6:0]} - 8'(carry_flag);
  end
  ////////////////////////////////////////////////////////////
  // jump steps
  sequence jump_take; take && op == OP_SHORT_JUMP; endsequence
  sequence jump_gap; !instr_ready && !pc_load; endsequence
  sequence jump_end; pc_load && exec_done && instr_ready; endsequence
  ////////////////////////////////////////////////////////////
  rot_right_a: assert property (
    take && op == OP_ROT_RIGHT |=> acc == {$past(acc[0]), $past(acc[7:1])} && exec_done)
    else $error("rotate right result wrong");
  rot_flags_a: assert property (
    take && op == OP_ROT_RIGHT && !flag_load |=> $stable({carry_flag, aux_carry_flag, overflow_flag}))
    else $error("rotate right changed flags");
  rot_carry_a: assert property (
    take && op == OP_ROT_RIGHT_CY |=> acc == {$past(carry_flag), $past(acc[7:1])} && carry_flag == $past(acc[0]))
    else $error("rotate through carry wrong");
  set_carry_a: assert property (
    take && op == OP_SET_CARRY |=> carry_flag && exec_done)
    else $error("set carry failed");
  set_bit_a: assert property (
    take && op == OP_SET_BIT && !flag_load |=> bit_wr_en && exec_done && bit_wr_addr == $past(instr_byte2)
      && $stable({carry_flag, aux_carry_flag, overflow_flag}))
    else $error("set addressed bit wrong");
  jump_steps_a: assert property (
    jump_take |=> jump_gap ##1 jump_end)
    else $error("short jump timing wrong");
  jump_target_a: assert property (
    jump_take |=> ##1 pc_target == $past(instr_pc, 2) + 16'h0002
      + {{8{$past(instr_byte2[7], 2)}}, $past(instr_byte2, 2)})
    else $error("short jump target wrong");
  sub_acc_a: assert property (
    take && is_sub |=> acc == $past(d8[7:0]) && carry_flag == $past(d8[8]))
    else $error("subtract result or carry wrong");
  sub_aux_a: assert property (
    take && is_sub |=> aux_carry_flag == $past(d3[4]))
    else $error("subtract aux carry wrong");
  sub_ovf_a: assert property (
    take && is_sub |=> overflow_flag == ($past(d8[8]) ^ $past(d6[7])))
    else $error("subtract overflow wrong");
  sub_src_a: assert property (
    take && (op & OP_SUB_REG_MASK) == OP_SUB_REG |-> src_rd_en && src_mode == SRC_REG
      && src_addr == {5'h00, op[2:0]})
    else $error("register operand select wrong");
endmodule : rsjx_exec_assertions

bind rsjx_exec rsjx_exec_assertions i_rsjx_exec_assertions (.*);

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import rsjx_pkg::*;
  logic        clk_sys, srst, instr_valid, instr_ready, src_rd_en, acc_load, flag_load;
  logic        carry_flag, aux_carry_flag, overflow_flag, bit_wr_en, pc_load, exec_done, illegal_op;
  logic [7:0]  instr_opcode, instr_byte2, src_addr, src_data, acc_load_data, acc, bit_wr_addr;
  logic [15:0] instr_pc, pc_target;
  logic [2:0]  flag_load_data;
  rsjx_src_t   src_mode;
  rsjx_src_t   cap_mode;
  logic        cap_rd;
  logic [7:0]  cap_addr;
  int          err_total = 0;
  int          checks_done = 0;

  rsjx_exec i_rsjx_exec (.*);

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  // shared tasks
  function automatic logic [2:0] flg();
    return {carry_flag, aux_carry_flag, overflow_flag};
  endfunction : flg

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic load(input logic [7:0] a, input logic [2:0] f);
    acc_load       <= 1'h1;
    acc_load_data  <= a;
    flag_load      <= 1'h1;
    flag_load_data <= f;
    @(posedge clk_sys);
    acc_load  <= 1'h0;
    flag_load <= 1'h0;
    #1;
  endtask : load

  task automatic issue(input logic [7:0] op, input logic [7:0] b2, input logic [15:0] pc);
    instr_opcode <= op;
    instr_byte2  <= b2;
    instr_pc     <= pc;
    instr_valid  <= 1'h1;
    #1;
    cap_rd   = src_rd_en;
    cap_mode = src_mode;
    cap_addr = src_addr;
    @(posedge clk_sys);
    instr_valid <= 1'h0;
    #1;
  endtask : issue
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_rotate;
    load(8'hC5, 3'h5);
    issue(OP_ROT_RIGHT, 8'h00, 16'h0000);
    chk("rr_acc", 8'hE2, acc);
    chk("rr_done", 1'h1, exec_done);
    issue(OP_ROT_RIGHT, 8'h00, 16'h0001);
    chk("rr_acc2", 8'h71, acc);
    chk("rr_flags", 3'h5, flg());
  endtask : t_rotate

  task automatic t_rotcy;
    load(8'hC5, 3'h3);
    issue(OP_ROT_RIGHT_CY, 8'h00, 16'h0000);
    chk("rrc_acc", 8'h62, acc);
    chk("rrc_flags", 3'h7, flg());
    issue(OP_ROT_RIGHT_CY, 8'h00, 16'h0001);
    chk("rrc_acc2", 8'hB1, acc);
    chk("rrc_flags2", 3'h3, flg());
  endtask : t_rotcy

  task automatic t_set_bit_op;
    load(8'h5A, 3'h0);
    issue(OP_SET_BIT, 8'h90, 16'h0001);
    chk("set_bit_op_en", 1'h1, bit_wr_en);
    chk("set_bit_op_addr", 8'h90, bit_wr_addr);
    chk("set_bit_op_done", 1'h1, exec_done);
    chk("set_bit_op_flags", 3'h0, flg());
    chk("set_bit_op_acc", 8'h5A, acc);
    issue(OP_SET_CARRY, 8'h00, 16'h0000);
    chk("setc_flags", 3'h4, flg());
    chk("setc_done", 1'h1, exec_done);
    chk("setc_pulse", 1'h0, bit_wr_en);
    chk("setc_ill", 1'h0, illegal_op);
  endtask : t_set_bit_op

  task automatic t_jump;
    logic [15:0] pcs[5] = '{16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'hFFFF};
    logic [7:0]  rel[5] = '{8'h21, 8'hFE, 8'h80, 8'h7F, 8'h01};
    logic [15:0] tgt[5] = '{16'h0123, 16'h0100, 16'h0182, 16'h0281, 16'h0002};
    load(8'h00, 3'h0);
    for (int i = 0; i < 5; i++) begin
      issue(OP_SHORT_JUMP, rel[i], pcs[i]);
      chk("jmp_ready", 1'h0, instr_ready);
      chk("jmp_early", 1'h0, pc_load);
      instr_opcode <= OP_SET_CARRY;
      instr_valid  <= 1'h1;
      @(posedge clk_sys);
      instr_valid <= 1'h0;
      #1;
      chk("jmp_load", 1'h1, pc_load);
      chk("jmp_done", 1'h1, exec_done);
      chk("jmp_target", tgt[i], pc_target);
      chk("jmp_refused", 1'h0, carry_flag);
    end
  endtask : t_jump

  task automatic t_sub;
    logic [7:0] ops[6] = '{8'h9A, 8'h95, 8'h97, 8'h94, 8'h9F, 8'h96};
    logic [7:0] accs[6] = '{8'hC9, 8'hC9, 8'hC9, 8'hC9, 8'h00, 8'h80};
    logic [7:0] opd[6] = '{8'h54, 8'h54, 8'h54, 8'h54, 8'h01, 8'h01};
    logic [7:0] res[6] = '{8'h74, 8'h74, 8'h74, 8'h74, 8'hFF, 8'h7F};
    logic [2:0] fin[6] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h3, 3'h0};
    logic [2:0] fout[6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h6, 3'h3};
    logic [1:0] mode[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    logic [7:0] addr[6] = '{8'h02, 8'h54, 8'h01, 8'h54, 8'h07, 8'h00};
    for (int i = 0; i < 6; i++) begin
      load(accs[i], fin[i]);
      src_data <= (ops[i] == OP_SUB_IMM) ? 8'hFF : opd[i];
      issue(ops[i], opd[i], 16'h0000);
      chk("sub_acc", res[i], acc);
      chk("sub_carry", fout[i][2], carry_flag);
      chk("sub_aux", fout[i][1], aux_carry_flag);
      chk("sub_ovf", fout[i][0], overflow_flag);
      chk("sub_rd", ops[i] != OP_SUB_IMM, cap_rd);
      chk("sub_mode", mode[i], cap_mode);
      chk("sub_addr", addr[i], cap_addr);
    end
  endtask : t_sub

  task automatic t_misc;
    chk("rst_acc", 8'h00, acc);
    chk("rst_flags", 3'h0, flg());
    chk("rst_ready", 1'h1, instr_ready);
    chk("rst_target", 16'h0000, pc_target);
    load(8'h3C, 3'h2);
    issue(8'h00, 8'h00, 16'h0000);
    chk("ill_flag", 1'h1, illegal_op);
    chk("ill_done", 1'h0, exec_done);
    chk("ill_acc", 8'h3C, acc);
  endtask : t_misc
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    srst <= 1'h1;
    {instr_valid, acc_load, flag_load} <= 3'h0;
    {instr_opcode, instr_byte2, src_data, acc_load_data} <= 32'h0;
    instr_pc <= 16'h0000;
    flag_load_data <= 3'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    #1;
    t_misc;
    t_rotate;
    t_rotcy;
    t_set_bit_op;
    t_jump;
    t_sub;
    finish_test;
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end
endmodule : tb
